// *** inc/adc_ctrl_pkg.sv ***
// constants, enumerations and carriers for the converter control block
// assumes a single 50 mhz peripheral clock and a 16-bit register port
package adc_ctrl_pkg;

  // ==========================================================
  // register port
  localparam int          ADDR_W       = 3;
  localparam int          DATA_W       = 16;
  localparam logic [2:0]  OFF_CTRL     = 3'h0;
  localparam logic [2:0]  OFF_CONF     = 3'h1;
  localparam logic [2:0]  OFF_MUX      = 3'h2;
  localparam logic [2:0]  OFF_EVT      = 3'h3;
  localparam logic [2:0]  OFF_CMP      = 3'h4;
  localparam logic [2:0]  OFF_RES      = 3'h5;
  localparam logic [2:0]  OFF_STAT     = 3'h6;

  // ==========================================================
  // field positions
  localparam int          CTRL_ENABLE  = 0;
  localparam int          CTRL_START   = 1;
  localparam int          CTRL_FLUSH   = 2;
  localparam int          CONF_SIGNED  = 0;
  localparam int          CONF_RES_LO  = 1;
  localparam int          CONF_REF_LO  = 3;
  localparam int          MUX_MODE_LO  = 0;
  localparam int          MUX_POS_LO   = 2;
  localparam int          MUX_NEG_LO   = 6;
  localparam int          MUX_INT_LO   = 8;
  localparam int          MUX_GAIN_LO  = 10;
  localparam int          EVT_CMP_EN   = 4;
  localparam int          EVT_ABOVE    = 5;
  localparam int          STAT_FLAG    = 0;
  localparam int          STAT_BUSY    = 1;
  localparam int          NUM_CHAN     = 4;
  localparam int          RAW_W        = 12;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_CONF     = 16'h0000;
  localparam logic [15:0] RST_MUX      = 16'h0000;
  localparam logic [15:0] RST_EVT      = 16'h0000;
  localparam logic [11:0] RST_CMP      = 12'h000;

  // ==========================================================
  // conversion length in clocks: base plus half the resolution plus gain
  localparam logic [3:0]  CONV_BASE    = 4'h1;
  localparam logic [3:0]  HALF_RES8    = 4'h4;
  localparam logic [3:0]  HALF_RES12   = 4'h6;
  localparam logic [3:0]  NEG_HIGH_BASE = 4'h4;

  typedef enum logic [1:0] {
    MEAS_DIFF      = 2'h0,
    MEAS_DIFF_GAIN = 2'h1,
    MEAS_SINGLE    = 2'h2,
    MEAS_INTERNAL  = 2'h3
  } meas_t;

  typedef enum logic [1:0] {
    twelve_right_adjusted = 2'h0,
    res_reserved          = 2'h1,
    eight_right_adjusted  = 2'h2,
    twelve_left_adjusted  = 2'h3
  } res_t;

  typedef enum logic [1:0] {
    NEG_PIN      = 2'h0,
    NEG_GROUND   = 2'h1,
    NEG_HALF_REF = 2'h2
  } neg_t;

  typedef enum logic [1:0] {
    INT_TEMP       = 2'h0,
    INT_BANDGAP    = 2'h1,
    INT_SUPPLY_D10 = 2'h2
  } internal_t;

  typedef enum logic [1:0] {
    REF_INT_1V00   = 2'h0,
    REF_SUPPLY_D16 = 2'h1,
    REF_EXT_PORT_A = 2'h2,
    REF_EXT_PORT_B = 2'h3
  } ref_t;

  typedef enum logic [2:0] {
    GAIN_1X = 3'h0, GAIN_2X = 3'h1, GAIN_4X = 3'h2, GAIN_8X = 3'h3,
    GAIN_16X = 3'h4, GAIN_32X = 3'h5, GAIN_64X = 3'h6, GAIN_HALF = 3'h7
  } gain_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_CONV   = 2'b01,
    ST_FINISH = 2'b11
  } state_t;

  // routing handed to the analog core
  typedef struct packed {
    logic [3:0] pos_pin;
    logic       pos_internal;
    internal_t  internal_sel;
    neg_t       neg_kind;
    logic [2:0] neg_pin;
    logic       gain_en;
    gain_t      gain;
    ref_t       ref_sel;
  } route_t;

endpackage

// *** verif/adc_input_result_control_bench.sv ***
// self-checking bench for the converter control block
// assumes the package, core model and checker are compiled before it
`timescale 1ns/1ns
module adc_input_result_control_bench;
  import adc_ctrl_pkg::*;
  logic        clk_sys       = 1'b0;
  logic        rst_b         = 1'b0;
  logic [2:0]  reg_addr      = 3'h0;
  logic [15:0] reg_wdata     = 16'h0000;
  logic        reg_write     = 1'b0;
  logic        reg_read      = 1'b0;
  logic [3:0]  event_channel = 4'h0;
  logic [11:0] code          = 12'h000;
  logic [15:0] reg_rdata;
  logic [11:0] conv_raw;
  logic        conv_start, conv_eight, irq_request, conv_event;
  route_t      route;
  int          mismatches    = 0;
  int          checks        = 0;
  int          n, n8, n12;
  logic [11:0] raws [3]      = '{12'h800, 12'h7ff, 12'hfff};
  logic [1:0]  r;

  always #10 clk_sys = ~clk_sys;

  adc_input_result_control i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .event_channel(event_channel), .conv_raw(conv_raw), .conv_start(conv_start),
    .conv_eight(conv_eight), .route(route), .irq_request(irq_request), .conv_event(conv_event));
  analog_core_model i_core (.clk_sys(clk_sys), .conv_start(conv_start), .code(code),
    .conv_raw(conv_raw));

  // ==========================================================
  // bus tasks and checks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask

  // bounded wait; a missed compare must keep the flag low the whole span
  task automatic wait_flag(input logic exp, output int k);
    k = 0;
    while (irq_request !== 1'b1 && k < 30) begin
      @(posedge clk_sys);
      #1 k++;
    end
    chk("irq_request", {15'h0, irq_request}, {15'h0, exp});
    if (irq_request === 1'b1)
      wr(OFF_STAT, 16'h0001);
  endtask

  task automatic conv(input logic [11:0] raw, input logic exp, output int k);
    code <= raw;
    wr(OFF_CTRL, 16'h0003);
    wait_flag(exp, k);
  endtask

  function automatic logic [15:0] fmt(input logic s, input logic [1:0] m, input logic [11:0] x);
    if (m == 2'b11)
      return {x, 4'h0};
    if (m == 2'b10)
      return {{8{s & x[11]}}, x[11:4]};
    return {{4{s & x[11]}}, x};
  endfunction

  task automatic complete_run();
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++)
      rd(3'(a), 16'h0000);
    wr(OFF_CONF, 16'h0001);
    wr(OFF_MUX, 16'h00e4);
    @(posedge clk_sys);
    #1 chk("neg_pin", {13'h0, route.neg_pin}, 16'h0003);
    chk("pos_pin", {12'h0, route.pos_pin}, 16'h0009);
    for (int g = 0; g < 8; g++) begin
      wr(OFF_MUX, {3'h0, 3'(g), 2'h0, 2'h2, 4'h9, 2'h1});
      @(posedge clk_sys);
      #1 chk("gain", {13'h0, route.gain}, 16'(g));
      chk("neg_pin", {13'h0, route.neg_pin}, 16'h0006);
    end
    for (int rf = 0; rf < 4; rf++) begin
      wr(OFF_CONF, {11'h0, 2'(rf), 3'h1});
      @(posedge clk_sys);
      #1 chk("ref_sel", {14'h0, route.ref_sel}, 16'(rf));
    end
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CONF, 16'(i / 3));
      wr(OFF_MUX, {6'h0, 2'(i % 3), 6'h0, 2'h3});
      @(posedge clk_sys);
      #1 chk("internal_sel", {14'h0, route.internal_sel}, 16'(i % 3));
      chk("neg_kind", {14'h0, route.neg_kind}, (i < 3) ? 16'h0002 : 16'h0001);
    end
    for (int m = 0; m < 6; m++) begin
      r = (m < 2) ? 2'b00 : (m < 4) ? 2'b10 : 2'b11;
      wr(OFF_CONF, {13'h0, r, 1'(m)});
      wr(OFF_MUX, 16'h0016);
      for (int j = 0; j < 3; j++) begin
        conv(raws[j], 1'b1, n);
        rd(OFF_RES, fmt(1'(m), r, raws[j]));
        if (r == 2'b10)
          n8 = n;
        else
          n12 = n;
      end
      rd(OFF_CTRL, 16'h0001);
      chk("conv_eight", {15'h0, conv_eight}, {15'h0, r == 2'b10});
    end
    chk("rate", 16'(n8 < n12), 16'h0001);
    wr(OFF_CONF, 16'h0000);
    wr(OFF_CMP, 16'h0400);
    wr(OFF_EVT, 16'h0030);
    conv(12'h400, 1'b0, n);
    conv(12'h401, 1'b1, n);
    wr(OFF_EVT, 16'h0010);
    conv(12'h3ff, 1'b1, n);
    conv(12'h400, 1'b0, n);
    // signed mode reads the threshold as minus one
    wr(OFF_CONF, 16'h0001);
    wr(OFF_CMP, 16'h0fff);
    wr(OFF_EVT, 16'h0030);
    conv(12'h001, 1'b1, n);
    wr(OFF_EVT, 16'h0004);
    wr(OFF_CTRL, 16'h0001);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_sys);
      event_channel <= 4'(1 << c);
      @(posedge clk_sys);
      event_channel <= 4'h0;
      wait_flag(c == 2, n);
    end
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    complete_run();
  end
endmodule

// *** verif/adc_input_result_control_props.sv ***
// assertions on the ports of the converter control block
// assumes the package is compiled first; bound to the top module below
`timescale 1ns/1ns
module adc_input_result_control_props (
  input wire logic                                clk_sys,
  input wire logic                                rst_b,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0]     reg_addr,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0]     reg_wdata,
  input wire logic                                reg_write,
  input wire logic                                reg_read,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0]     reg_rdata,
  input wire logic [adc_ctrl_pkg::NUM_CHAN-1:0]   event_channel,
  input wire logic [adc_ctrl_pkg::RAW_W-1:0]      conv_raw,
  input wire logic                                conv_start,
  input wire logic                                conv_eight,
  input wire adc_ctrl_pkg::route_t                route,
  input wire logic                                irq_request,
  input wire logic                                conv_event
);
  import adc_ctrl_pkg::*;
  // ==========================================================
  // sign mode shadow, since the ports do not carry it
  logic signed_sh;
  wire  conf_wr  = reg_write && reg_addr == OFF_CONF;
  wire  mux_wr   = reg_write && reg_addr == OFF_MUX;
  wire  stat_clr = reg_write && reg_addr == OFF_STAT && reg_wdata[STAT_FLAG];
  always_ff @(posedge clk_sys) begin
    if (!rst_b)
      signed_sh <= 1'b0;
    else if (conf_wr)
      signed_sh <= reg_wdata[CONF_SIGNED];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // routing, timing and flag
  a_plain_neg_low: assert property (
    route.neg_kind == NEG_PIN && !route.gain_en |-> route.neg_pin < 3'h4)
    else $error("plain negative pin above three");
  a_gain_neg_high: assert property (
    route.gain_en |-> route.neg_pin[2] && route.neg_kind == NEG_PIN)
    else $error("gained negative pin below four");
  a_single_neg_ref: assert property (
    mux_wr && reg_wdata[1] |-> ##2 route.neg_kind == ($past(signed_sh) ? NEG_GROUND : NEG_HALF_REF))
    else $error("single or internal negative input misrouted");
  a_internal_sel: assert property (
    mux_wr && reg_wdata[1:0] == MEAS_INTERNAL
    |-> ##2 route.pos_internal && route.internal_sel == $past(reg_wdata[9:8], 2))
    else $error("internal source not routed");
  a_gain_value: assert property (
    mux_wr && reg_wdata[1:0] == MEAS_DIFF_GAIN
    |-> ##2 route.gain_en && route.gain == $past(reg_wdata[12:10], 2))
    else $error("gain setting not routed");
  a_ref_follow: assert property (
    conf_wr |-> ##2 route.ref_sel == $past(reg_wdata[4:3], 2))
    else $error("reference selection not routed");
  a_twelve_time: assert property (
    conv_event && !conv_eight && !route.gain_en |-> $past(conv_start, 8))
    else $error("12-bit completion at wrong cycle");
  a_eight_time: assert property (
    conv_event && conv_eight && !route.gain_en |-> $past(conv_start, 6))
    else $error("8-bit completion at wrong cycle");
  a_flag_hold: assert property (
    $fell(irq_request) |-> $past(stat_clr) || $past(stat_clr, 2) || !$past(rst_b))
    else $error("flag dropped without clear");
  a_event_flag: assert property (
    conv_event |-> irq_request)
    else $error("event without flag");
endmodule

bind adc_input_result_control adc_input_result_control_props i_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .event_channel(event_channel), .conv_raw(conv_raw), .conv_start(conv_start),
  .conv_eight(conv_eight), .route(route), .irq_request(irq_request), .conv_event(conv_event)
);

// *** verif/analog_core_model.sv ***
// behavioural analog core: answers each conversion start with a code
// assumes the bench sets the code before it starts a conversion
`timescale 1ns/1ns
module analog_core_model (
  input  wire logic        clk_sys,
  input  wire logic        conv_start,
  input  wire logic [11:0] code,
  output logic      [11:0] conv_raw
);
  // ==========================================================
  // code holds past the longest conversion; outside it the lines wander
  logic [3:0] left = 4'h0;
  logic       tog  = 1'b0;
  always_ff @(posedge clk_sys) begin
    tog <= ~tog;
    if (conv_start)
      left <= 4'hc;
    else if (left != 4'h0)
      left <= left - 4'h1;
  end
  assign conv_raw = (left != 4'h0) ? code : ~code ^ {12{tog}};
endmodule

// *** verilog/adc_input_result_control.sv ***
// converter control: input routing, start, sequencing, result format, compare
// assumes an analog core that holds a 12-bit code on conv_raw through the last conversion clock after conv_start
`timescale 1ns/1ns

//
// Operation
// - plain differential: any positive pin, negative pins 0 to 3
// - gained differential: any positive pin, negative pins 4 to 7
// - gain offers 1x to 64x in powers of two, plus half
// - signed single-ended: negative input goes to internal ground
// - unsigned single-ended or internal: negative input at half reference minus offset
// - internal sources: temperature, bandgap, supply divided by ten
// - reference: internal 1.00 V, supply over 1.6, external port A or B
// - signed 12-bit result spans -2048 to +2047 in two's complement
// - unsigned 12-bit result spans 0 to 4095
// - 16-bit result register; 8-bit result sits in the low byte
// - 12-bit result right or left adjusted; left puts top eight bits high
// - signed 12-bit right adjusted copies bit 11 into bits 12 to 15
// - signed 8-bit copies bit 7 across the high byte
// - 8-bit conversion finishes sooner than 12-bit
// - 12-bit threshold; compare flags only above or below as selected
// - start by software start bit or any enabled event channel
// - resolution code 00 12 right, 10 8 right, 11 12 left, 01 reserved
// - mode bit resets to unsigned; one selects signed
// - start bit cleared by hardware when the conversion begins
// - completion can raise interrupt request and event instead of compare
module adc_input_result_control (
  input  wire logic                             clk_sys,
  input  wire logic                             rst_b,
  input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [adc_ctrl_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                             reg_write,
  input  wire logic                             reg_read,
  output logic      [adc_ctrl_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic [adc_ctrl_pkg::NUM_CHAN-1:0] event_channel,
  input  wire logic [adc_ctrl_pkg::RAW_W-1:0]   conv_raw,
  output logic                                  conv_start,
  output logic                                  conv_eight,
  output adc_ctrl_pkg::route_t                  route,
  output logic                                  irq_request,
  output logic                                  conv_event
);
  import adc_ctrl_pkg::*;

  // ==========================================================
  // registers
  logic        enable;
  logic        start_pending;
  logic [15:0] conf;
  logic [15:0] mux;
  logic [15:0] evt;
  logic [11:0] threshold;
  logic [15:0] result;
  logic        flag;
  state_t      state;
  logic [3:0]  count;
  logic [11:0] raw_hold;

  // ==========================================================
  // decode
  wire logic wr_ctrl = reg_write && (reg_addr == OFF_CTRL);
  wire logic wr_conf = reg_write && (reg_addr == OFF_CONF);
  wire logic wr_mux  = reg_write && (reg_addr == OFF_MUX);
  wire logic wr_evt  = reg_write && (reg_addr == OFF_EVT);
  wire logic wr_cmp  = reg_write && (reg_addr == OFF_CMP);
  wire logic wr_stat = reg_write && (reg_addr == OFF_STAT);

  wire logic   sw_start  = wr_ctrl && reg_wdata[CTRL_START];
  wire logic   flush     = wr_ctrl && reg_wdata[CTRL_FLUSH];
  wire logic   ev_start  = |(event_channel & evt[NUM_CHAN-1:0]);
  wire logic   signed_md = conf[CONF_SIGNED];
  wire res_t   res_sel   = res_t'(conf[CONF_RES_LO +: 2]);
  wire ref_t   ref_sel   = ref_t'(conf[CONF_REF_LO +: 2]);
  wire meas_t  meas      = meas_t'(mux[MUX_MODE_LO +: 2]);
  wire gain_t  gain_sel  = gain_t'(mux[MUX_GAIN_LO +: 3]);
  wire logic   cmp_en    = evt[EVT_CMP_EN];
  wire logic   cmp_above = evt[EVT_ABOVE];
  wire logic   eight     = (res_sel == eight_right_adjusted);

  // ==========================================================
  // input routing
  wire logic is_diff   = (meas == MEAS_DIFF) || (meas == MEAS_DIFF_GAIN);
  wire logic is_gain   = (meas == MEAS_DIFF_GAIN);
  wire neg_t next_neg  = is_diff   ? NEG_PIN      :
                         signed_md ? NEG_GROUND   :
                                     NEG_HALF_REF;
  // negative pin picks from 0..3 plain, 4..7 through the gain stage
  wire logic [1:0] neg_field    = mux[MUX_NEG_LO +: 2];
  wire logic [2:0] next_neg_pin = is_gain ? {NEG_HIGH_BASE[2], neg_field}
                                          : {1'b0, neg_field};
  route_t next_route;
  assign next_route.pos_pin      = mux[MUX_POS_LO +: 4];
  assign next_route.pos_internal = (meas == MEAS_INTERNAL);
  assign next_route.internal_sel = internal_t'(mux[MUX_INT_LO +: 2]);
  assign next_route.neg_kind     = next_neg;
  assign next_route.neg_pin      = next_neg_pin;
  assign next_route.gain_en      = is_gain;
  assign next_route.gain         = gain_sel;
  assign next_route.ref_sel      = ref_sel;

  // ==========================================================
  // conversion length: the gain stage adds one to three clocks
  wire logic [3:0] gain_extra =
    !is_gain                                         ? 4'h0 :
    (gain_sel == GAIN_8X  || gain_sel == GAIN_16X)   ? 4'h2 :
    (gain_sel == GAIN_32X || gain_sel == GAIN_64X)   ? 4'h3 :
                                                       4'h1;
  wire logic [3:0] conv_len = CONV_BASE + (eight ? HALF_RES8 : HALF_RES12) + gain_extra;

  wire logic begin_conv = (state == ST_IDLE) && enable && start_pending && !flush;
  wire logic conv_last  = (state == ST_CONV) && (count == 4'h1);

  // ==========================================================
  // result formatting
  wire logic [7:0]  raw8  = raw_hold[11:4];
  wire logic [15:0] fmt_r12 = signed_md ? {{4{raw_hold[11]}}, raw_hold}
                                        : {4'h0, raw_hold};
  wire logic [15:0] fmt_r8  = signed_md ? {{8{raw8[7]}}, raw8}
                                        : {8'h00, raw8};
  wire logic [15:0] fmt_l12 = {raw_hold, 4'h0};
  wire logic [15:0] next_result = (res_sel == eight_right_adjusted) ? fmt_r8  :
                                  (res_sel == twelve_left_adjusted) ? fmt_l12 :
                                                                      fmt_r12;

  // ==========================================================
  // compare against the value being stored, so the flag and the register agree
  wire logic [15:0] thr16 = signed_md ? {{4{threshold[11]}}, threshold}
                                      : {4'h0, threshold};
  wire logic        above = signed_md ? ($signed(next_result) > $signed(thr16))
                                      : (next_result > thr16);
  wire logic        below = signed_md ? ($signed(next_result) < $signed(thr16))
                                      : (next_result < thr16);
  wire logic        hit   = cmp_en ? (cmp_above ? above : below) : 1'b1;
  wire logic        done  = (state == ST_FINISH) && hit;

  // ==========================================================
  // state machine
  state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (begin_conv) next_state = ST_CONV;
      ST_CONV:   if (flush) next_state = ST_IDLE;
                 else if (conv_last) next_state = ST_FINISH;
      ST_FINISH: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      count <= 4'h0;
    end else begin
      state <= next_state;
      count <= begin_conv ? conv_len : (count - 4'h1);
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      enable        <= 1'b0;
      start_pending <= 1'b0;
      conf          <= RST_CONF;
      mux           <= RST_MUX;
      evt           <= RST_EVT;
      threshold     <= RST_CMP;
    end else begin
      if (wr_ctrl) enable <= reg_wdata[CTRL_ENABLE];
      // a new request in the begin cycle survives the clear
      if (sw_start || ev_start) start_pending <= 1'b1;
      else if (begin_conv) start_pending <= 1'b0;
      if (wr_conf) conf <= reg_wdata;
      if (wr_mux) mux <= reg_wdata;
      if (wr_evt) evt <= reg_wdata;
      if (wr_cmp) threshold <= reg_wdata[11:0];
    end
  end

  // ==========================================================
  // result, flag and outputs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      raw_hold <= 12'h000;
      result   <= 16'h0000;
      flag     <= 1'b0;
    end else begin
      if (conv_last && !flush) raw_hold <= conv_raw;
      if (state == ST_FINISH) result <= next_result;
      // set wins over a write-one clear in the same cycle
      if (done) flag <= 1'b1;
      else if (wr_stat && reg_wdata[STAT_FLAG]) flag <= 1'b0;
    end
  end

  // result and flag land on the same edge, so a read after the flag sees it
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      conv_start  <= 1'b0;
      conv_eight  <= 1'b0;
      route       <= '0;
      irq_request <= 1'b0;
      conv_event  <= 1'b0;
    end else begin
      conv_start  <= begin_conv;
      conv_eight  <= eight;
      route       <= next_route;
      irq_request <= flag || done;
      conv_event  <= done;
    end
  end

  // ==========================================================
  // read port: data stand one cycle after the strobe
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    unique case (reg_addr)
      OFF_CTRL: rd_mux = {14'h0000, start_pending, enable};
      OFF_CONF: rd_mux = conf;
      OFF_MUX:  rd_mux = mux;
      OFF_EVT:  rd_mux = evt;
      OFF_CMP:  rd_mux = {4'h0, threshold};
      OFF_RES:  rd_mux = result;
      OFF_STAT: rd_mux = {14'h0000, (state != ST_IDLE), flag};
      default:  rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) reg_rdata <= 16'h0000;
    else if (reg_read) reg_rdata <= rd_mux;
    else reg_rdata <= 16'h0000;
  end

endmodule
